// File: hw/irq_arbiter.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// priority arbiter: high level first, then lowest source index
// ----------------------------------------------------------------
module irq_arbiter (
    irq_sel_if.arb sel
);

    // lowest set bit wins; fixed order between equal levels
    function automatic logic [4:0] first_set(input logic [17:0] vec);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = irq_ctrl_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
            if (vec[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : first_set

    wire logic [17:0] hi_req  = sel.req_vec & sel.hi_vec;   // high-level candidates
    wire logic        any_hi  = |hi_req;                    // a high request exists

    // high level beats low whenever both are present
    assign sel.valid = |sel.req_vec;
    assign sel.is_hi = any_hi;
    assign sel.index = any_hi ? first_set(hi_req) : first_set(sel.req_vec);

endmodule : irq_arbiter

`default_nettype wire

// File: hw/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

    // ----------------------------------------------------------------
    // source count and register layout
    // ----------------------------------------------------------------
    localparam int NUM_SOURCES       = 18;             // number of interrupt sources
    localparam int IDX_W             = 5;              // width of a source index
    localparam int GLOBAL_GATE_BIT   = 7;              // global gate inside the primary mask
    localparam int PRIMARY_SRC_BASE  = 0;              // first source held in the primary regs
    localparam int PRIMARY_SRC_CNT   = 7;              // sources held in the primary regs
    localparam int EXT1_SRC_BASE     = 7;              // first source held in extended regs 1
    localparam int EXT1_SRC_CNT      = 8;              // sources held in extended regs 1
    localparam int EXT2_SRC_BASE     = 15;             // first source held in extended regs 2
    localparam int EXT2_SRC_CNT      = 3;              // sources held in extended regs 2

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  MASK_RESET     = 8'h00;    // all enables off, gate off
    localparam logic [7:0]  PRIO_RESET     = 8'h00;    // every source low priority
    localparam logic [17:0] PEND_RESET     = 18'h00000; // no flag pending

    // sources whose flag is cleared by hardware when the call is taken
    localparam logic [17:0] HW_CLEAR_MASK  = 18'h1000F;

    // ----------------------------------------------------------------
    // vectors and timing
    // ----------------------------------------------------------------
    localparam logic [15:0] VECTOR_BASE    = 16'h0003; // vector of source 0
    localparam logic [15:0] VECTOR_STEP    = 16'h0008; // spacing between vectors
    localparam logic [2:0]  CALL_CYCLES    = 3'h4;     // cycles to complete the vector call

    // call sequencer states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CALL = 1'b1
    } call_state_type;

endpackage : irq_ctrl_pkg

// File: hw/irq_sel_if.sv
`timescale 1ns/1ps
`default_nettype none

// carries the eligible requests to the arbiter and its winner back
interface irq_sel_if;
    logic [17:0] req_vec;   // eligible requests, one per source
    logic [17:0] hi_vec;    // priority level per source, 1 = high
    logic        valid;     // some request won
    logic [4:0]  index;     // winning source
    logic        is_hi;     // winner is high priority

    modport arb (input req_vec, input hi_vec, output valid, output index, output is_hi);
    modport ctl (output req_vec, output hi_vec, input valid, input index, input is_hi);
endinterface : irq_sel_if

`default_nettype wire

// File: hw/vectored_interrupt_controller.sv
// Notes on behaviour
// - eighteen sources, each low or high priority
// - source condition sets its pending flag
// - flag sets regardless of any enable
// - enabled flag requests; call after instruction ends
// - return resumes the interrupted instruction stream
// - disabled source's flag causes no request
// - each source has own enable bit
// - enables count only while global gate set
// - global gate clear blocks every source
// - latched request taken if next instruction short
// - multi-cycle next instruction drops latched request
// - some flags hardware-cleared on call, others software
// - flag still set after return re-enters after one
// - high preempts low, high never preempted
// - higher level first, then fixed source order
// - sampled each cycle; detect one, call four
// - software writing one sets flag, acts like event
`timescale 1ns/1ps
`default_nettype none

module vectored_interrupt_controller #(
    parameter int NUM_SOURCES = irq_ctrl_pkg::NUM_SOURCES   // number of sources
) (
    input  wire logic        sys_clk,               // system clock
    input  wire logic        rst,                   // synchronous reset, active high
    input  wire logic [17:0] src_event,             // peripheral condition pulses
    input  wire logic [17:0] sw_pend_set,           // software writes 1 to a flag
    input  wire logic [17:0] sw_pend_clr,           // software clears a flag
    input  wire logic        primary_mask_wr,       // write strobe, primary enables
    input  wire logic        ext_mask1_wr,          // write strobe, extended enables 1
    input  wire logic        ext_mask2_wr,          // write strobe, extended enables 2
    input  wire logic        primary_prio_wr,       // write strobe, primary priorities
    input  wire logic        ext_prio1_wr,          // write strobe, extended priorities 1
    input  wire logic        ext_prio2_wr,          // write strobe, extended priorities 2
    input  wire logic [7:0]  reg_wdata,             // data for any register write
    input  wire logic        instr_done,            // core finishes an instruction
    input  wire logic        irq_return_done,       // core finishes the return op
    output logic [7:0]       primary_irq_mask_reg,  // enables 0..6, global gate at bit 7
    output logic [7:0]       extended_irq_mask_reg1,// enables 7..14
    output logic [7:0]       extended_irq_mask_reg2,// enables 15..17
    output logic [7:0]       primary_priority_reg,  // priorities 0..6
    output logic [7:0]       extended_priority_reg1,// priorities 7..14
    output logic [7:0]       extended_priority_reg2,// priorities 15..17
    output logic [17:0]      pend_flags,            // pending flags
    output logic             irq_request,           // a sampled request is waiting
    output logic             vector_call_busy,      // vector call in progress
    output logic             vector_call_done,      // last cycle of the vector call
    output logic [15:0]      call_vector,           // target address of the call
    output logic [4:0]       call_source,           // source being called
    output logic             service_hi,            // a high-level routine is active
    output logic             service_lo             // a low-level routine is active
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [17:0] pend_q;                 // pending flags
    logic [7:0]  pmask_q;                // primary enables and gate
    logic [7:0]  emask1_q;               // extended enables 1
    logic [2:0]  emask2_q;               // extended enables 2, upper bits reserved
    logic [6:0]  pprio_q;                // primary priorities, bit 7 reserved
    logic [7:0]  eprio1_q;               // extended priorities 1
    logic [2:0]  eprio2_q;               // extended priorities 2
    logic        req_q;                  // request seen in the detect cycle
    logic [4:0]  req_idx_q;              // its source
    logic        req_hi_q;               // its level
    irq_ctrl_pkg::call_state_type state_q; // call sequencer
    logic [2:0]  call_cnt_q;             // cycles left in the call
    logic [15:0] vec_q;                  // latched vector
    logic [4:0]  src_q;                  // latched source
    logic        call_hi_q;              // level of the call in flight
    logic        act_hi_q;               // high routine in service
    logic        act_lo_q;               // low routine in service
    logic        skip_q;                 // hold off one instruction after return

    // ----------------------------------------------------------------
    // enable and priority vectors
    // ----------------------------------------------------------------
    wire logic [17:0] en_vec = {emask2_q, emask1_q, pmask_q[6:0]};  // per-source enables
    wire logic [17:0] hi_vec = {eprio2_q, eprio1_q, pprio_q};       // per-source levels
    wire logic        gate   = pmask_q[irq_ctrl_pkg::GLOBAL_GATE_BIT];

    // flag and enable only; gate off hides everything
    wire logic [17:0] enabled = pend_q & en_vec & {18{gate}};

    // a low routine admits only high requests, a high routine admits none
    wire logic [17:0] admit   = act_hi_q ? 18'h00000 : (act_lo_q ? hi_vec : 18'h3FFFF);

    irq_sel_if sel ();
    assign sel.req_vec = enabled & admit;
    assign sel.hi_vec  = hi_vec;

    irq_arbiter u_arb (
        .sel (sel)
    );

    // the core takes the call only at an instruction boundary
    wire logic take    = (state_q == irq_ctrl_pkg::ST_IDLE) && instr_done && !skip_q && req_q;
    wire logic call_end = (state_q == irq_ctrl_pkg::ST_CALL) && (call_cnt_q == 3'h1);
    wire logic [17:0] take_onehot = 18'(18'h00001 << req_idx_q);
    // hardware clears listed flags when the call is taken
    wire logic [17:0] hw_clr  = take ? (take_onehot & irq_ctrl_pkg::HW_CLEAR_MASK) : 18'h00000;

    // ----------------------------------------------------------------
    // pending flags
    // ----------------------------------------------------------------
    // any set beats a clear in the same cycle, so no event is lost
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend_q <= irq_ctrl_pkg::PEND_RESET;
        end else begin
            pend_q <= (pend_q & ~(sw_pend_clr | hw_clr)) | src_event | sw_pend_set;
        end
    end

    // ----------------------------------------------------------------
    // enable and priority registers
    // ----------------------------------------------------------------
    // everything starts disabled and at low priority
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pmask_q  <= irq_ctrl_pkg::MASK_RESET;
            emask1_q <= irq_ctrl_pkg::MASK_RESET;
            emask2_q <= irq_ctrl_pkg::MASK_RESET[2:0];
            pprio_q  <= irq_ctrl_pkg::PRIO_RESET[6:0];
            eprio1_q <= irq_ctrl_pkg::PRIO_RESET;
            eprio2_q <= irq_ctrl_pkg::PRIO_RESET[2:0];
        end else begin
            if (primary_mask_wr) begin
                pmask_q <= reg_wdata;
            end
            if (ext_mask1_wr) begin
                emask1_q <= reg_wdata;
            end
            if (ext_mask2_wr) begin
                emask2_q <= reg_wdata[2:0];
            end
            if (primary_prio_wr) begin
                pprio_q <= reg_wdata[6:0];
            end
            if (ext_prio1_wr) begin
                eprio1_q <= reg_wdata;
            end
            if (ext_prio2_wr) begin
                eprio2_q <= reg_wdata[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // detect stage
    // ----------------------------------------------------------------
    // re-sampled every cycle: a request seen while an enable is being
    // cleared survives one cycle, so a single-cycle next instruction can
    // still take it; a longer one sees it vanish before its boundary.
    // software avoids the race with a two-byte opcode after the clear.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_q     <= 1'b0;
            req_idx_q <= 5'h00;
            req_hi_q  <= 1'b0;
        end else begin
            req_q     <= sel.valid;
            req_idx_q <= sel.index;
            req_hi_q  <= sel.is_hi;
        end
    end

    // ----------------------------------------------------------------
    // vector call sequencer
    // ----------------------------------------------------------------
    // four cycles of call after the detect cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q    <= irq_ctrl_pkg::ST_IDLE;
            call_cnt_q <= 3'h0;
            vec_q      <= 16'h0000;
            src_q      <= 5'h00;
            call_hi_q  <= 1'b0;
        end else begin
            case (state_q)
                irq_ctrl_pkg::ST_IDLE: begin
                    if (take) begin
                        state_q    <= irq_ctrl_pkg::ST_CALL;
                        call_cnt_q <= irq_ctrl_pkg::CALL_CYCLES;
                        vec_q      <= irq_ctrl_pkg::VECTOR_BASE
                                      + 16'(req_idx_q * irq_ctrl_pkg::VECTOR_STEP);
                        src_q      <= req_idx_q;
                        call_hi_q  <= req_hi_q;
                    end
                end
                irq_ctrl_pkg::ST_CALL: begin
                    call_cnt_q <= call_cnt_q - 3'h1;
                    if (call_end) begin
                        state_q <= irq_ctrl_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= irq_ctrl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // in-service levels and return handling
    // ----------------------------------------------------------------
    // the return closes the highest active level; the interrupted stream
    // resumes and one instruction runs before any new call
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            act_hi_q <= 1'b0;
            act_lo_q <= 1'b0;
            skip_q   <= 1'b0;
        end else begin
            if (call_end && call_hi_q) begin
                act_hi_q <= 1'b1;
            end else if (call_end) begin
                act_lo_q <= 1'b1;
            end else if (irq_return_done && act_hi_q) begin
                act_hi_q <= 1'b0;
            end else if (irq_return_done) begin
                act_lo_q <= 1'b0;
            end
            if (irq_return_done) begin
                skip_q <= 1'b1;
            end else if (instr_done) begin
                skip_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign primary_irq_mask_reg   = pmask_q;
    assign extended_irq_mask_reg1 = emask1_q;
    assign extended_irq_mask_reg2 = {5'h00, emask2_q};
    assign primary_priority_reg   = {1'b0, pprio_q};
    assign extended_priority_reg1 = eprio1_q;
    assign extended_priority_reg2 = {5'h00, eprio2_q};
    assign pend_flags             = pend_q;
    assign irq_request            = req_q;
    assign vector_call_busy       = (state_q == irq_ctrl_pkg::ST_CALL);
    assign vector_call_done       = call_end;
    assign call_vector            = vec_q;
    assign call_source            = src_q;
    assign service_hi             = act_hi_q;
    assign service_lo             = act_lo_q;

endmodule : vectored_interrupt_controller

`default_nettype wire

// File: tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// core stand-in: instruction boundaries and returns
// ------------------------------------------------
module core_model (
    input  wire logic       sys_clk,          // system clock
    input  wire logic       rst,              // synchronous reset
    input  wire logic [3:0] gap,              // idle cycles per instruction
    input  wire logic       in_service,       // a routine is running
    input  wire logic       busy,             // vector call in progress
    output logic            instr_done,       // instruction finished
    output logic            irq_return_done   // return op finished
);
    logic [3:0] cnt_q;   // cycles into the current instruction
    logic [4:0] isr_q;   // instructions run inside a routine
    // a routine runs eleven instructions then returns, long enough for a preempting request
    // a return replaces the boundary pulse, never both at once
    always_ff @(posedge sys_clk) begin
        instr_done      <= 1'b0;
        irq_return_done <= 1'b0;
        if (rst) begin
            cnt_q <= 4'h0;
            isr_q <= 5'h00;
        end else if (!busy) begin
            cnt_q <= (cnt_q >= gap) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q >= gap && in_service && isr_q == 5'h0B) begin
                irq_return_done <= 1'b1;
                isr_q           <= 5'h00;
            end else if (cnt_q >= gap) begin
                instr_done <= 1'b1;
                isr_q      <= in_service ? isr_q + 5'h01 : 5'h00;
            end
        end
    end
endmodule : core_model
`default_nettype wire

// File: tb/vectored_interrupt_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// self-checking bench for the interrupt controller
// ------------------------------------------------
module vectored_interrupt_controller_tb;
    logic        sys_clk, rst, instr_done, irq_return_done, irq_request;
    logic        vector_call_busy, vector_call_done, service_hi, service_lo;
    logic [17:0] src_event, sw_pend_set, sw_pend_clr, pend_flags;
    logic [7:0]  reg_wdata, primary_irq_mask_reg, extended_irq_mask_reg1, extended_irq_mask_reg2;
    logic [7:0]  primary_priority_reg, extended_priority_reg1, extended_priority_reg2;
    logic [5:0]  wr_strb;      // one write strobe per register
    logic [15:0] call_vector;
    logic [4:0]  call_source, s, s_exp;
    logic [3:0]  gap;          // core pacing, drawn at random
    logic [4:0]  exp_q[$];     // sources expected to be called, oldest first
    logic [4:0]  src_list[6] = '{5'h04, 5'h00, 5'h09, 5'h10, 5'h11, 5'h03};
    integer      error_cnt = 0, tests_run = 0, seed = 96475, cyc = 0;
    vectored_interrupt_controller #(.NUM_SOURCES(18)) DUT (.primary_mask_wr(wr_strb[0]), .ext_mask1_wr(wr_strb[1]),
        .ext_mask2_wr(wr_strb[2]), .primary_prio_wr(wr_strb[3]), .ext_prio1_wr(wr_strb[4]),
        .ext_prio2_wr(wr_strb[5]), .*);
    core_model u_core (.sys_clk(sys_clk), .rst(rst), .gap(gap), .in_service(service_hi | service_lo),
        .busy(vector_call_busy), .instr_done(instr_done), .irq_return_done(irq_return_done));
    // ------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // a hung wait must still reach the verdict
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // strobe falls for a cycle between writes, so back-to-back calls are safe
    task automatic wr(input int k, input logic [7:0] d);
        tick(1);
        wr_strb   <= 6'h01 << k;
        reg_wdata <= d;
        tick(1);
        wr_strb   <= 6'h00;
    endtask : wr
    task automatic set_flags(input logic [17:0] v);
        tick(1);
        sw_pend_set <= v;
        tick(1);
        sw_pend_set <= 18'h00000;
    endtask : set_flags
    task automatic clr_flag(input logic [4:0] k);
        tick(1);
        sw_pend_clr <= 18'h00001 << k;
        tick(1);
        sw_pend_clr <= 18'h00000;
    endtask : clr_flag
    // waits for the end of a call to one source; the service routine may clear it
    task automatic wait_call(input logic [4:0] k, input bit clr);
        int n;
        n = 0;
        tick(1);
        while (!(vector_call_done === 1'b1 && call_source === k) && n < 300) begin
            tick(1);
            n++;
        end
        if (n >= 300) check(32'h0, 32'h1);
        if (clr) clr_flag(k);
    endtask : wait_call
    task automatic settle();
        int n;
        n = 0;
        while ((service_hi | service_lo | vector_call_busy) !== 1'b0 && n < 400) begin
            tick(1);
            n++;
        end
        if (n >= 400) check(32'h0, 32'h1);
        tick(4);
    endtask : settle
    // ------------------------------------------------
    // monitor: every finished call must match the oldest note
    // ------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rst && vector_call_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h0, 32'h1);
            end else begin
                s_exp = exp_q.pop_front();
                check(call_source, s_exp);
                check(call_vector, 16'h0003 + {8'h00, s_exp, 3'h0});
            end
        end
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        rst = 1'b1;
        src_event = 18'h00000;
        sw_pend_set = 18'h00000;
        sw_pend_clr = 18'h00000;
        wr_strb = 6'h00;
        reg_wdata = 8'h00;
        gap = 4'h1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        check({extended_irq_mask_reg2, extended_irq_mask_reg1, primary_irq_mask_reg}, 24'h000000);
        check(primary_priority_reg, 8'h00);
        $display("test reset done");
        s = 5'($unsigned($random(seed)) % 18);
        src_event <= 18'h00001 << s;
        tick(1);
        src_event <= 18'h00000;
        tick(2);
        check(pend_flags, 18'h00001 << s);
        tick(20);
        clr_flag(s);
        tick(1);
        check(pend_flags, 18'h00000);
        $display("test disabled source done");
        wr(0, 8'h80);
        wr(1, 8'hFF);
        wr(2, 8'hFF);
        set_flags(18'h00020);
        tick(20);
        clr_flag(5'h05);
        check(extended_irq_mask_reg2, 8'h07);
        wr(0, 8'hFF);
        foreach (src_list[i]) begin
            s = src_list[i];
            gap <= 4'($unsigned($random(seed)) % 3);
            exp_q.push_back(s);
            set_flags(18'h00001 << s);
            wait_call(s, 1'b0);
            check(pend_flags[s], !irq_ctrl_pkg::HW_CLEAR_MASK[s]);
            clr_flag(s);
            settle();
        end
        $display("test vectored calls done");
        wr(0, 8'h7F);
        wr(0, 8'h7F);
        set_flags(18'h00010);
        tick(20);
        clr_flag(5'h04);
        wr(0, 8'hFF);
        $display("test gate closed done");
        wr(4, 8'h04);
        exp_q.push_back(5'h09);
        exp_q.push_back(5'h04);
        set_flags(18'h00210);
        wait_call(5'h09, 1'b1);
        wait_call(5'h04, 1'b1);
        settle();
        exp_q.push_back(5'h05);
        exp_q.push_back(5'h09);
        set_flags(18'h00020);
        wait_call(5'h05, 1'b1);
        set_flags(18'h00200);
        wait_call(5'h09, 1'b1);
        check(service_lo, 1'b1);
        settle();
        wr(3, 8'($random(seed)));
        tick(1);
        check(primary_priority_reg, {1'b0, reg_wdata[6:0]});
        wr(5, 8'($random(seed)));
        tick(1);
        check({extended_priority_reg2, extended_priority_reg1}, {5'h00, reg_wdata[2:0], 8'h04});
        $display("test priority done");
        exp_q.push_back(5'h06);
        exp_q.push_back(5'h06);
        set_flags(18'h00040);
        wait_call(5'h06, 1'b0);
        wait_call(5'h06, 1'b1);
        settle();
        check(exp_q.size(), 32'h0);
        $display("test re-entry done");
        finish_test();
    end
endmodule : vectored_interrupt_controller_tb
bind vectored_interrupt_controller vic_asserts #(.NUM_SOURCES(NUM_SOURCES)) u_chk (.*);
`default_nettype wire

// File: tb/vic_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// port-level checks of the interrupt controller
// ------------------------------------------------
module vic_asserts #(
    parameter int NUM_SOURCES = 18   // handed on from the design
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [17:0] src_event,
    input wire logic [17:0] sw_pend_set,
    input wire logic        instr_done,
    input wire logic [7:0]  primary_irq_mask_reg,
    input wire logic [7:0]  extended_irq_mask_reg1,
    input wire logic [7:0]  extended_irq_mask_reg2,
    input wire logic [7:0]  primary_priority_reg,
    input wire logic [7:0]  extended_priority_reg1,
    input wire logic [7:0]  extended_priority_reg2,
    input wire logic [17:0] pend_flags,
    input wire logic        irq_request,
    input wire logic        vector_call_busy,
    input wire logic        vector_call_done,
    input wire logic [15:0] call_vector,
    input wire logic [4:0]  call_source,
    input wire logic        service_hi,
    input wire logic        service_lo
);
    // ------------------------------------------------
    // helper views of the register outputs
    // ------------------------------------------------
    logic [17:0] en_vec;   // per-source enables
    logic [17:0] hi_vec;   // per-source level, 1 = high
    logic        armed;    // an enabled flag with the gate open
    assign en_vec = {extended_irq_mask_reg2[2:0], extended_irq_mask_reg1, primary_irq_mask_reg[6:0]};
    assign hi_vec = {extended_priority_reg2[2:0], extended_priority_reg1, primary_priority_reg[6:0]};
    assign armed  = primary_irq_mask_reg[7] && |(en_vec & pend_flags);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // reset is watched through its own edge, so it may not disable itself
    a_reset_clear: assert property (disable iff (1'b0) rst |=> (primary_irq_mask_reg == 8'h00
        && pend_flags == 18'h00000 && !irq_request && !vector_call_busy)) else $error("state not cleared by reset");
    a_flag_sets: assert property ((src_event | sw_pend_set) != 18'h00000 |=>
        (pend_flags & ($past(src_event) | $past(sw_pend_set))) == ($past(src_event) | $past(sw_pend_set)))
        else $error("pending flag did not set");
    a_gate_blocks: assert property (!primary_irq_mask_reg[7] |=> !irq_request)
        else $error("request with the gate closed");
    a_req_cause: assert property (irq_request |-> $past(armed))
        else $error("request without an enabled flag");
    a_call_len: assert property ($rose(vector_call_busy) |-> vector_call_busy[*4] ##1 !vector_call_busy)
        else $error("vector call not four cycles long");
    a_done_last: assert property ($rose(vector_call_busy) |-> !vector_call_done[*3] ##1 vector_call_done)
        else $error("call done not on fourth cycle");
    a_vector_map: assert property (vector_call_busy |-> call_vector == 16'h0003 + {8'h00, call_source, 3'h0})
        else $error("call vector does not match source");
    a_take_cause: assert property ($rose(vector_call_busy) |-> $past(instr_done) && $past(irq_request))
        else $error("call without request at a boundary");
    a_hi_final: assert property ($rose(vector_call_busy) |-> !$past(service_hi))
        else $error("high routine was preempted");
    a_lo_preempt: assert property ($rose(vector_call_busy) && $past(service_lo) |-> hi_vec[call_source])
        else $error("low routine preempted by low source");
    a_service_on: assert property (vector_call_done |=> service_hi || service_lo)
        else $error("no routine active after call");
endmodule : vic_asserts
`default_nettype wire
